// ===== src/fsch_top.sv
`timescale 1ns/100ps
// Functional notes
// - store holds 119 independently addressed blocks of 512 bytes
// - header: code, options, block, offset, count; data from byte 8
// - two-byte header fields travel most significant byte first
// - count gives trailing data bytes, or bytes wanted for a read
// - unicast request gets a unicast reply to its source endpoint
// - broadcast requests are executed but never answered
// - reply marked explicit when source endpoint is 0xE6 or mode set
// - reply reuses header layout, code echoed with bit 7 set, status at byte 1
// - status bit 0 set on failure, other status bits reserved
// - geometry reply code 0x80 carries block count in block field
// - geometry reply carries block size in offset field
// - geometry and erase replies report zero count and no data
// - code 0x01 erases, leaving affected blocks all ones
// - erase with zero count wipes every block, block field ignored
// - erase acts on whole blocks only; offset field unused
module fsch_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // incoming command frame bytes
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  input wire logic cmd_bcast,
  input wire logic [7:0] cmd_src_ep,
  input wire logic [7:0] cmd_dst_ep,
  input wire logic [15:0] cmd_cluster,
  output logic cmd_ready,
  // configuration
  input wire logic explicit_api_en,
  // flash erase port
  output logic fl_erase_req,
  output logic fl_erase_all,
  output logic [6:0] fl_erase_blk,
  input wire logic fl_done,
  input wire logic fl_fail,
  // reply bytes
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  output logic [7:0] rsp_dst_ep,
  output logic rsp_rx_ind,
  input wire logic rsp_ready
);
  typedef enum logic [1:0] {
    S_RECV,
    S_EXEC,
    S_ERASE,
    S_RESP
  } fsch_state_t;

  typedef struct packed {
    fsch_state_t st;
    logic [63:0] hdr;
    logic [3:0] nb;
    logic bcast;
    logic [7:0] src_ep;
    logic rx_ind;
    logic [63:0] rsp;
    logic [2:0] ridx;
    logic cmd_rdy;
    logic er_req;
    logic er_all;
    logic [6:0] er_blk;
  } fsch_top_st_t;

  fsch_top_st_t s_r;
  fsch_top_st_t s_nxt;

  // header fields, big-endian as shifted in
  logic [7:0] h_code;
  logic [15:0] h_blk;
  logic [15:0] h_off;
  logic [15:0] h_cnt;
  logic take;
  logic addr_ok;
  logic blk_bad;
  logic buf_in_ready;
  fsch_pkg::fsch_rsp_t push_word;
  fsch_pkg::fsch_rsp_t out_word;

  // fixed field positions of the eight-byte header
  assign h_code = s_r.hdr[63:56];
  assign h_blk = s_r.hdr[47:32];
  assign h_off = s_r.hdr[31:16];
  assign h_cnt = s_r.hdr[15:0];
  assign take = cmd_valid && s_r.cmd_rdy;
  // frames for any other service are swallowed without a reply
  assign addr_ok = (cmd_cluster == fsch_pkg::SVC_CLUSTER) &&
    (cmd_dst_ep == fsch_pkg::SVC_ENDPOINT);
  assign blk_bad = (h_blk >= fsch_pkg::BLK_COUNT);

  // reply bytes leave most significant byte first
  always_comb begin
    push_word.data = s_r.rsp[63:56];
    push_word.last = (s_r.ridx == fsch_pkg::RSP_LAST_IDX);
    push_word.dst_ep = s_r.src_ep;
    push_word.rx_ind = s_r.rx_ind;
  end

  // main sequencer
  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      S_RECV: begin
        if (take) begin
          if (s_r.nb < fsch_pkg::HDR_LEN) begin
            s_nxt.hdr = {s_r.hdr[55:0], cmd_data};
            s_nxt.nb = s_r.nb + 4'h1;
          end
          // data bytes past the header are absorbed; no command here
          // in this block carries any
          if (cmd_last) begin
            s_nxt.nb = 4'h0;
            s_nxt.bcast = cmd_bcast;
            s_nxt.src_ep = cmd_src_ep;
            s_nxt.rx_ind = (cmd_src_ep == fsch_pkg::SVC_ENDPOINT) ||
              explicit_api_en;
            // short frames are dropped: too little to echo a header
            if (addr_ok && (s_r.nb >= 4'h7)) begin
              s_nxt.st = S_EXEC;
              s_nxt.cmd_rdy = 1'b0;
            end
          end
        end
      end
      S_EXEC: begin
        // layout echoes the request, status at byte 1, no data
        s_nxt.rsp = {h_code | fsch_pkg::RSP_FLAG, 8'h00, h_blk, h_off,
          16'h0000};
        s_nxt.ridx = 3'h0;
        if (h_code == fsch_pkg::CMD_GEOMETRY) begin
          // options and fields of the query are not checked
          s_nxt.rsp[47:16] = {fsch_pkg::BLK_COUNT,
            fsch_pkg::BLK_SIZE};
        end else if (h_code == fsch_pkg::CMD_ERASE) begin
          if (h_cnt == 16'h0000) begin
            s_nxt.er_all = 1'b1;
            s_nxt.er_blk = 7'h00;
          end else begin
            s_nxt.er_all = 1'b0;
            s_nxt.er_blk = h_blk[6:0];
          end
          if (blk_bad && (h_cnt != 16'h0000)) begin
            s_nxt.rsp[55:48] = fsch_pkg::STATUS_ERR;
          end else begin
            s_nxt.er_req = 1'b1;
          end
        end else begin
          s_nxt.rsp[55:48] = fsch_pkg::STATUS_ERR;
        end
        if (s_nxt.er_req) begin
          s_nxt.st = S_ERASE;
        end else if (s_r.bcast) begin
          s_nxt.st = S_RECV;
          s_nxt.cmd_rdy = 1'b1;
        end else begin
          s_nxt.st = S_RESP;
        end
      end
      S_ERASE: begin
        // request is held until the flash reports completion
        if (fl_done) begin
          s_nxt.er_req = 1'b0;
          if (fl_fail) begin
            s_nxt.rsp[55:48] = fsch_pkg::STATUS_ERR;
          end
          if (s_r.bcast) begin
            s_nxt.st = S_RECV;
            s_nxt.cmd_rdy = 1'b1;
          end else begin
            s_nxt.st = S_RESP;
          end
        end
      end
      S_RESP: begin
        if (buf_in_ready) begin
          s_nxt.rsp = {s_r.rsp[55:0], 8'h00};
          s_nxt.ridx = s_r.ridx + 3'h1;
          if (s_r.ridx == fsch_pkg::RSP_LAST_IDX) begin
            s_nxt.st = S_RECV;
            s_nxt.cmd_rdy = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= S_RECV;
      s_r.cmd_rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // two-entry buffer so a stalled receiver loses no reply byte
  fsch_buf2 u_buf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(s_r.st == S_RESP),
    .in_data(push_word),
    .in_ready(buf_in_ready),
    .out_valid(rsp_valid),
    .out_data(out_word),
    .out_ready(rsp_ready)
  );

  assign rsp_data = out_word.data;
  assign rsp_last = out_word.last;
  assign rsp_dst_ep = out_word.dst_ep;
  assign rsp_rx_ind = out_word.rx_ind;
  assign cmd_ready = s_r.cmd_rdy;
  assign fl_erase_req = s_r.er_req;
  assign fl_erase_all = s_r.er_all;
  assign fl_erase_blk = s_r.er_blk;

  // checks on the sequencer
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_hdr_shift;
    (take && s_r.nb < fsch_pkg::HDR_LEN) |=>
      s_r.hdr[7:0] == $past(cmd_data) &&
      s_r.hdr[15:8] == $past(s_r.hdr[7:0]);
  endproperty
  a_hdr_shift: assert property (p_hdr_shift)
    else $error("header byte not shifted in");

  property p_geom;
    (s_r.st == S_EXEC && h_code == fsch_pkg::CMD_GEOMETRY) |=>
      s_r.rsp == 64'h8000_0077_0200_0000;
  endproperty
  a_geom: assert property (p_geom)
    else $error("geometry reply malformed");

  property p_echo;
    s_r.st == S_EXEC |=>
      s_r.rsp[63:56] == ($past(h_code) | 8'h80) && s_r.rsp[15:0] == 0;
  endproperty
  a_echo: assert property (p_echo)
    else $error("reply code or count wrong");

  property p_bcast;
    s_r.bcast |-> s_r.st != S_RESP;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("reply sent for broadcast");

  property p_unicast;
    (s_r.st == S_EXEC && !s_r.bcast && h_code != 8'h01) |=>
      s_r.st == S_RESP ##8 s_r.st == S_RECV || !buf_in_ready;
  endproperty
  a_unicast: assert property (p_unicast)
    else $error("unicast request not answered");

  property p_erase_all;
    (s_r.st == S_EXEC && h_code == 8'h01 && h_cnt == 16'h0000) |=>
      fl_erase_req && fl_erase_all;
  endproperty
  a_erase_all: assert property (p_erase_all)
    else $error("erase-all not requested");

  property p_blk_err;
    (s_r.st == S_EXEC && h_code == 8'h01 && h_cnt != 0 && blk_bad) |=>
      !fl_erase_req && s_r.rsp[48];
  endproperty
  a_blk_err: assert property (p_blk_err)
    else $error("bad block not refused");

  property p_hold;
    (fl_erase_req && !fl_done) |=> fl_erase_req && $stable(fl_erase_blk);
  endproperty
  a_hold: assert property (p_hold)
    else $error("erase request dropped early");

  property p_reserved;
    (s_r.st == S_RESP && s_r.ridx == 3'h0) |-> s_r.rsp[55:49] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits set");

  // frames that cannot be answered leave the block ready for the next
  property p_short_drop;
    (take && cmd_last && s_r.nb < 4'h7) |=>
      s_r.st == S_RECV && s_r.cmd_rdy;
  endproperty
  a_short_drop: assert property (p_short_drop)
    else $error("short frame not dropped");

  property p_addr_drop;
    (take && cmd_last && !addr_ok) |=> s_r.st == S_RECV && s_r.cmd_rdy;
  endproperty
  a_addr_drop: assert property (p_addr_drop)
    else $error("misaddressed frame not dropped");

  // the explicit marking follows the last byte's endpoint and mode
  property p_rx_ind;
    (take && cmd_last) |=>
      s_r.rx_ind == (($past(cmd_src_ep) == fsch_pkg::SVC_ENDPOINT) ||
      $past(explicit_api_en));
  endproperty
  a_rx_ind: assert property (p_rx_ind)
    else $error("explicit marking wrong");

  // a single erase names the block from the header, never all
  property p_single;
    (s_r.st == S_EXEC && h_code == fsch_pkg::CMD_ERASE &&
      h_cnt != 16'h0000 && !blk_bad) |=>
      fl_erase_req && !fl_erase_all && fl_erase_blk == h_blk[6:0];
  endproperty
  a_single: assert property (p_single)
    else $error("single-block erase not requested");

  property p_done;
    (fl_erase_req && fl_done) |=> !fl_erase_req;
  endproperty
  a_done: assert property (p_done)
    else $error("erase request outlived completion");

  property p_fail;
    (s_r.st == S_ERASE && fl_done && fl_fail) |=> s_r.rsp[48];
  endproperty
  a_fail: assert property (p_fail)
    else $error("flash failure not reported");

  // main scenarios reached
  c_geom: cover property (s_r.st == S_EXEC && h_code == 8'h00);
  c_erase_all: cover property (fl_erase_req && fl_erase_all && fl_done);
  c_stall: cover property (rsp_valid && !rsp_ready && !buf_in_ready);
  c_bcast_erase: cover property (s_r.st == S_ERASE && s_r.bcast && fl_done);
  c_drop: cover property (take && cmd_last && s_r.nb < 4'h7);
endmodule : fsch_top

// ===== src/fsch_pkg.sv
package fsch_pkg;
  // store geometry
  localparam logic [15:0] BLK_COUNT = 16'h0077;
  localparam logic [15:0] BLK_SIZE = 16'h0200;
  // addressing of the memory-access service
  localparam logic [15:0] SVC_CLUSTER = 16'h0023;
  localparam logic [7:0] SVC_ENDPOINT = 8'he6;
  // command and reply codes
  localparam logic [7:0] CMD_GEOMETRY = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h01;
  localparam logic [7:0] RSP_FLAG = 8'h80;
  localparam logic [7:0] STATUS_ERR = 8'h01;
  // header layout
  localparam logic [3:0] HDR_LEN = 4'h8;
  localparam logic [2:0] RSP_LAST_IDX = 3'h7;

  // one reply byte travelling to the link
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic [7:0] dst_ep;
    logic rx_ind;
  } fsch_rsp_t;
endpackage : fsch_pkg

// ===== src/fsch_buf2.sv
`timescale 1ns/100ps
module fsch_buf2 (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  input fsch_pkg::fsch_rsp_t in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output fsch_pkg::fsch_rsp_t out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic v0;
    logic v1;
    fsch_pkg::fsch_rsp_t e0;
    fsch_pkg::fsch_rsp_t e1;
    logic rdy;
  } fsch_buf_st_t;

  fsch_buf_st_t s_r;
  fsch_buf_st_t s_nxt;

  // head slot drives the output; second slot catches a word during a stall
  always_comb begin
    s_nxt = s_r;
    if (s_r.v0 && out_ready) begin
      s_nxt.e0 = s_r.e1;
      s_nxt.v0 = s_r.v1;
      s_nxt.v1 = 1'b0;
    end
    if (in_valid && s_r.rdy) begin
      if (!s_nxt.v0) begin
        s_nxt.e0 = in_data;
        s_nxt.v0 = 1'b1;
      end else begin
        s_nxt.e1 = in_data;
        s_nxt.v1 = 1'b1;
      end
    end
    // ready is registered, so it looks one word ahead
    s_nxt.rdy = !s_nxt.v1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready = s_r.rdy;
  assign out_valid = s_r.v0;
  assign out_data = s_r.e0;
endmodule : fsch_buf2

// ===== verification/fsch_flash_model.sv
`timescale 1ns/100ps
module fsch_flash_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // erase port
  input wire logic fl_erase_req,
  input wire logic fail_mode,
  output logic fl_done,
  output logic fl_fail
);
  logic [3:0] wait_r;
  // finish each erase late; fail is junk outside the done pulse
  always_ff @(posedge mclk) begin
    if (rst || !fl_erase_req || fl_done) begin
      wait_r <= 4'h0;
      fl_done <= 1'b0;
      fl_fail <= !fail_mode;
    end else if (wait_r == 4'h5) begin
      fl_done <= 1'b1;
      fl_fail <= fail_mode;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : fsch_flash_model

// ===== verification/fsch_top_tb_top.sv
`timescale 1ns/100ps
module fsch_top_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0, cmd_last = 1'b0, cmd_bcast = 1'b0;
  logic [7:0] cmd_data = 8'h00, cmd_src_ep = 8'h00, cmd_dst_ep = 8'h00;
  logic [15:0] cmd_cluster = 16'h0000;
  logic explicit_api_en = 1'b0, rsp_ready = 1'b1, fail_mode = 1'b0;
  logic cmd_ready, fl_erase_req, fl_erase_all, fl_done, fl_fail;
  logic rsp_valid, rsp_last, rsp_rx_ind, fl_all_s;
  logic [6:0] fl_erase_blk, fl_blk_s;
  logic [7:0] rsp_data, rsp_dst_ep;
  int num_errors = 0, checks = 0, cyc = 0, n_req = 0, n_rsp = 0;
  fsch_top dut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_bcast(cmd_bcast),
    .cmd_src_ep(cmd_src_ep), .cmd_dst_ep(cmd_dst_ep),
    .cmd_cluster(cmd_cluster), .cmd_ready(cmd_ready),
    .explicit_api_en(explicit_api_en), .fl_erase_req(fl_erase_req),
    .fl_erase_all(fl_erase_all), .fl_erase_blk(fl_erase_blk),
    .fl_done(fl_done), .fl_fail(fl_fail), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_dst_ep(rsp_dst_ep),
    .rsp_rx_ind(rsp_rx_ind), .rsp_ready(rsp_ready));
  fsch_flash_model flash (.mclk(mclk), .rst(rst),
    .fl_erase_req(fl_erase_req), .fail_mode(fail_mode),
    .fl_done(fl_done), .fl_fail(fl_fail));
  always #4 mclk = ~mclk;
  // watch the erase port and reply stream; hang guard last
  always @(posedge mclk) begin
    cyc++;
    if (rsp_valid === 1'b1) n_rsp++;
    if (fl_erase_req === 1'b1) begin
      n_req++;
      fl_all_s = fl_erase_all;
      fl_blk_s = fl_erase_blk;
    end
    if (cyc > 20000) begin
      num_errors++;
      results();
    end
  end
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
        exp);
    end
  endtask : check
  // one header byte per accepted edge, most significant field first;
  // bytes past the header are filler data
  task send(input logic [63:0] hdr, input logic bc, input logic [7:0] src,
    input logic [7:0] dst, input logic [15:0] cl, input int len);
    logic [63:0] h;
    h = hdr;
    for (int i = 0; i < len; i++) begin
      cmd_valid <= 1'b1;
      cmd_data <= h[63:56];
      cmd_last <= (i == len - 1);
      cmd_bcast <= bc;
      cmd_src_ep <= src;
      cmd_dst_ep <= dst;
      cmd_cluster <= cl;
      @(posedge mclk);
      while (cmd_ready !== 1'b1) @(posedge mclk);
      h = {h[55:0], 8'ha5};
    end
    cmd_valid <= 1'b0;
    cmd_last <= 1'b0;
  endtask : send
  // stall holds ready low a while so the buffer fills and must refuse
  task expect_rsp(input logic [63:0] exp, input logic [7:0] ep,
    input logic ind, input logic stall);
    logic [63:0] got;
    logic [7:0] lst;
    int n, k;
    got = 64'h0;
    lst = 8'h00;
    n = 0;
    k = 0;
    while (n < 8) begin
      rsp_ready <= !(stall && k < 12);
      k++;
      @(posedge mclk);
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        got = {got[55:0], rsp_data};
        lst = {lst[6:0], rsp_last};
        n++;
        if (n == 8) begin
          check(rsp_dst_ep, ep);
          check(rsp_rx_ind, ind);
        end
      end
    end
    rsp_ready <= 1'b1;
    check(got, exp);
    check(lst, 8'h01);
  endtask : expect_rsp
  task no_rsp;
    n_rsp = 0;
    repeat (30) @(posedge mclk);
    check(n_rsp, 0);
  endtask : no_rsp
  task t_geom(input logic [7:0] src, input logic en, input logic ind,
    input logic stall);
    explicit_api_en <= en;
    send(64'h0, 1'b0, src, fsch_pkg::SVC_ENDPOINT, fsch_pkg::SVC_CLUSTER,
      8);
    expect_rsp(64'h8000_0077_0200_0000, src, ind, stall);
  endtask : t_geom
  task t_erase(input logic [63:0] hdr, input logic fail, input logic all,
    input logic [6:0] blk, input logic [63:0] exp, input logic req);
    fail_mode <= fail;
    explicit_api_en <= 1'b0;
    n_req = 0;
    send(hdr, 1'b0, 8'h11, fsch_pkg::SVC_ENDPOINT, fsch_pkg::SVC_CLUSTER,
      8);
    expect_rsp(exp, 8'h11, 1'b0, 1'b0);
    check(n_req != 0, req);
    if (req) begin
      check(fl_all_s, all);
      check(fl_blk_s, blk);
    end
  endtask : t_erase
  // broadcasts run but stay silent; misaddressed frames are dropped
  task t_silent;
    n_req = 0;
    send(64'h0100_0009_0000_0200, 1'b1, 8'h11, fsch_pkg::SVC_ENDPOINT,
      fsch_pkg::SVC_CLUSTER, 8);
    no_rsp();
    check(n_req != 0, 1'b1);
    send(64'h0, 1'b0, 8'h11, fsch_pkg::SVC_ENDPOINT, 16'h0024, 8);
    no_rsp();
    send(64'h0, 1'b0, 8'h11, 8'he7, fsch_pkg::SVC_CLUSTER, 8);
    no_rsp();
  endtask : t_silent
  // a header cut short is dropped; data past the header is absorbed
  task t_length;
    explicit_api_en <= 1'b0;
    send(64'h0, 1'b0, 8'h11, fsch_pkg::SVC_ENDPOINT, fsch_pkg::SVC_CLUSTER,
      7);
    no_rsp();
    send(64'h0900_0004_0000_0002, 1'b0, 8'h11, fsch_pkg::SVC_ENDPOINT,
      fsch_pkg::SVC_CLUSTER, 10);
    expect_rsp(64'h8901_0004_0000_0000, 8'h11, 1'b0, 1'b0);
  endtask : t_length
  task results;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge mclk);
    check({cmd_ready, rsp_valid, fl_erase_req}, 3'h4);
    rst <= 1'b0;
    t_geom(8'he6, 1'b0, 1'b1, 1'b0);
    t_geom(8'h11, 1'b0, 1'b0, 1'b1);
    t_geom(8'h11, 1'b1, 1'b1, 1'b0);
    t_erase(64'h0100_002a_0000_0200, 1'b0, 1'b0, 7'h2a,
      64'h8100_002a_0000_0000, 1'b1);
    t_erase(64'h0100_0005_0000_0000, 1'b0, 1'b1, 7'h00,
      64'h8100_0005_0000_0000, 1'b1);
    t_erase(64'h0100_0003_0000_0200, 1'b1, 1'b0, 7'h03,
      64'h8101_0003_0000_0000, 1'b1);
    t_erase(64'h0100_0077_0000_0200, 1'b0, 1'b0, 7'h00,
      64'h8101_0077_0000_0000, 1'b0);
    t_erase(64'h0700_0001_0004_0000, 1'b0, 1'b0, 7'h00,
      64'h8701_0001_0004_0000, 1'b0);
    t_silent();
    t_length();
    results();
  end
endmodule : fsch_top_tb_top
